// ---- design/gpi_cfg.svh ----
`ifndef GPI_CFG_SVH
`define GPI_CFG_SVH
// Port register byte offsets
`define GPI_DIR      9'h000
`define GPI_DIR_SET  9'h004
`define GPI_DIR_CLR  9'h008
`define GPI_DATA     9'h00C
`define GPI_DATA_SET 9'h010
`define GPI_DATA_CLR 9'h014
`define GPI_EDGE     9'h018
`define GPI_BOTH     9'h01C
`define GPI_POL      9'h020
`define GPI_PIN      9'h024
// Channel block base and stride shift
`define GPI_CH_BASE  9'h040
`define GPI_CH_SHIFT 5
// Offsets inside one channel block
`define GPI_C_ASSIGN 5'h00
`define GPI_C_MSK_S  5'h04
`define GPI_C_MSK_C  5'h08
`define GPI_C_REQ    5'h0C
`define GPI_C_LATCH  5'h10
`define GPI_C_PINST  5'h14
// Summary interrupt registers
`define GPI_STS      9'h100
`define GPI_STS_MSK  9'h104
// Assignment byte layout
`define GPI_ASG_EN   7
// Reset value for every register except the pad enables, which reset high
`define GPI_RST      32'h0000_0000
`endif

// ---- design/gpi_pkg.sv ----
package gpi_pkg;
   typedef logic [31:0] gpi_word_t;
   typedef logic [8:0] gpi_addr_t;
endpackage : gpi_pkg

// ---- design/gpi_pint.sv ----
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "gpi_cfg.svh"
// What this block does
// - Each pin has its own direction bit choosing input or output.
// - Set and clear writes touch only the pins whose written bit is one.
// - Each channel has its own mask bit per lane pin deciding whether that pin may interrupt it.
// - Input pins interrupt from the pin, output pins from software-written data.
// - Each pin picks level or edge, and for edge rising only or both edges.
// - Any pin can request by edge or level with software-chosen polarity.
// - Detection runs whatever the pin's direction or data setting.
// - Six interrupt channels each drive their own request line.
// - A channel sees at most thirty-two pins.
// - Pins reach channels in groups of eight, each group assigned by software.
// - Each channel has 32-bit registers for assignment, mask, request and clear.
// - Pin states and latches read back whether masked or not.
// - Channel masks have a set address and a clear address for write-one.
module gpi_pint
   import gpi_pkg::*;
#(
   parameter int NPIN = 32,
   parameter int NCH = 6
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire gpi_addr_t addr_i,
   input wire gpi_word_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [NPIN-1:0] gpio_in_i,
   output gpi_word_t rdata_o,
   output logic [NPIN-1:0] gpio_out_o,
   output logic [NPIN-1:0] gpio_oe_n_o,
   output logic [NCH-1:0] ch_irq_o,
   output logic irq_o
);
   localparam int NHP = NPIN / 8;
   localparam int HW = (NHP > 1) ? $clog2(NHP) : 1;

   // Picks one eight-pin group out of the port vector
   function automatic logic [7:0] grp(input logic [NPIN-1:0] v, input logic [HW-1:0] i);
      grp = v[{i, 3'b000} +: 8];
   endfunction : grp

   logic [NPIN-1:0] s1_ff, s2_ff, prev_ff;
   logic [NPIN-1:0] dir_ff, out_ff, edge_ff, both_ff, pol_ff, lat_ff;
   logic [NPIN-1:0] nxt_dir, nxt_out, nxt_lat;
   logic [NPIN-1:0] src, lvl, rise, fall, hit, clr;
   logic [NCH-1:0][31:0] asg_ff, msk_ff, nxt_asg, nxt_msk, chl, chp;
   logic [NCH-1:0] req, sts_ff, smsk_ff, nxt_sts;
   gpi_word_t rd_mux;
   gpi_addr_t ch_rel;
   logic [3:0] ch_sel;
   logic [4:0] ch_off;
   logic in_ch, sts_rd;

   // Address decode for the port registers
   wire w_dir = wr_i && addr_i == `GPI_DIR;
   wire w_dir_s = wr_i && addr_i == `GPI_DIR_SET;
   wire w_dir_c = wr_i && addr_i == `GPI_DIR_CLR;
   wire w_dat = wr_i && addr_i == `GPI_DATA;
   wire w_dat_s = wr_i && addr_i == `GPI_DATA_SET;
   wire w_dat_c = wr_i && addr_i == `GPI_DATA_CLR;
   wire w_edge = wr_i && addr_i == `GPI_EDGE;
   wire w_both = wr_i && addr_i == `GPI_BOTH;
   wire w_pol = wr_i && addr_i == `GPI_POL;
   wire w_smsk = wr_i && addr_i == `GPI_STS_MSK;
   wire [NPIN-1:0] wd = wdata_i[NPIN-1:0];

   // Channel window decode: block index and offset
   assign ch_rel = addr_i - `GPI_CH_BASE;
   assign ch_sel = ch_rel[8:`GPI_CH_SHIFT];
   assign ch_off = ch_rel[`GPI_CH_SHIFT-1:0];
   assign in_ch = (addr_i >= `GPI_CH_BASE) && (ch_sel < 4'(NCH));
   assign sts_rd = rd_i && addr_i == `GPI_STS;

   // Two-stage synchroniser; only the second stage feeds logic
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_ff <= '0;
         s2_ff <= '0;
      end else begin
         s1_ff <= gpio_in_i;
         s2_ff <= s1_ff;
      end
   end

   // Write-one set and clear leave the other pins alone
   assign nxt_dir = w_dir ? wd : w_dir_s ? (dir_ff | wd) :
                    w_dir_c ? (dir_ff & ~wd) : dir_ff;
   assign nxt_out = w_dat ? wd : w_dat_s ? (out_ff | wd) :
                    w_dat_c ? (out_ff & ~wd) : out_ff;

   // Outputs watch their own data so software can fire them
   assign src = (dir_ff & out_ff) | (~dir_ff & s2_ff);
   assign lvl = src ^ pol_ff;
   assign rise = lvl & ~(prev_ff ^ pol_ff);
   assign fall = ~lvl & (prev_ff ^ pol_ff);
   assign hit = (edge_ff & (rise | (both_ff & fall))) | (~edge_ff & lvl);
   // Set wins over a clear in the same cycle, so no event is lost
   assign nxt_lat = (lat_ff & ~clr) | hit;

   // Port configuration and latch registers
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir_ff <= `GPI_RST;
         out_ff <= `GPI_RST;
         edge_ff <= `GPI_RST;
         both_ff <= `GPI_RST;
         pol_ff <= `GPI_RST;
         lat_ff <= `GPI_RST;
         prev_ff <= `GPI_RST;
      end else begin
         dir_ff <= nxt_dir;
         out_ff <= nxt_out;
         edge_ff <= w_edge ? wd : edge_ff;
         both_ff <= w_both ? wd : both_ff;
         pol_ff <= w_pol ? wd : pol_ff;
         lat_ff <= nxt_lat;
         prev_ff <= src;
      end
   end

   // Pads: enable is low while the pin drives
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gpio_out_o <= '0;
         gpio_oe_n_o <= '1;
      end else begin
         gpio_out_o <= out_ff;
         gpio_oe_n_o <= ~dir_ff;
      end
   end

   // Channel mapping: each byte lane names one half-port, so a channel
   // never sees more than 32 pins and groups move only as a whole
   always_comb begin
      clr = '0;
      chl = '0;
      chp = '0;
      nxt_asg = asg_ff;
      nxt_msk = msk_ff;
      for (int c = 0; c < NCH; c++) begin
         for (int b = 0; b < 4; b++) begin
            if (asg_ff[c][8*b+`GPI_ASG_EN]) begin
               chl[c][8*b +: 8] = grp(lat_ff, asg_ff[c][8*b +: HW]);
               chp[c][8*b +: 8] = grp(s2_ff, asg_ff[c][8*b +: HW]);
               if (wr_i && in_ch && ch_sel == 4'(c) && ch_off == `GPI_C_LATCH) begin
                  clr[{asg_ff[c][8*b +: HW], 3'b000} +: 8] |= wdata_i[8*b +: 8];
               end
            end
         end
         if (wr_i && in_ch && ch_sel == 4'(c)) begin
            case (ch_off)
               `GPI_C_ASSIGN: nxt_asg[c] = wdata_i;
               `GPI_C_MSK_S: nxt_msk[c] = msk_ff[c] | wdata_i;
               `GPI_C_MSK_C: nxt_msk[c] = msk_ff[c] & ~wdata_i;
               default: nxt_msk[c] = msk_ff[c];
            endcase
         end
         req[c] = |(chl[c] & msk_ff[c]);
      end
   end

   // Summary status: sticky per channel, cleared by reading it
   assign nxt_sts = (sts_ff & ~{NCH{sts_rd}}) | req;

   // Channel registers and interrupt lines
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         asg_ff <= '0;
         msk_ff <= '0;
         sts_ff <= '0;
         smsk_ff <= '0;
         ch_irq_o <= '0;
         irq_o <= 1'b0;
      end else begin
         asg_ff <= nxt_asg;
         msk_ff <= nxt_msk;
         sts_ff <= nxt_sts;
         smsk_ff <= w_smsk ? wdata_i[NCH-1:0] : smsk_ff;
         ch_irq_o <= req;
         irq_o <= |(nxt_sts & smsk_ff);
      end
   end

   // Read selection; unmapped addresses read as zero
   always_comb begin
      rd_mux = '0;
      if (in_ch) begin
         case (ch_off)
            `GPI_C_ASSIGN: rd_mux = asg_ff[ch_sel];
            `GPI_C_MSK_S, `GPI_C_MSK_C: rd_mux = msk_ff[ch_sel];
            `GPI_C_REQ: rd_mux = chl[ch_sel] & msk_ff[ch_sel];
            `GPI_C_LATCH: rd_mux = chl[ch_sel];
            `GPI_C_PINST: rd_mux = chp[ch_sel];
            default: rd_mux = '0;
         endcase
      end else begin
         case (addr_i)
            `GPI_DIR, `GPI_DIR_SET, `GPI_DIR_CLR: rd_mux[NPIN-1:0] = dir_ff;
            `GPI_DATA, `GPI_DATA_SET, `GPI_DATA_CLR: rd_mux[NPIN-1:0] = out_ff;
            `GPI_EDGE: rd_mux[NPIN-1:0] = edge_ff;
            `GPI_BOTH: rd_mux[NPIN-1:0] = both_ff;
            `GPI_POL: rd_mux[NPIN-1:0] = pol_ff;
            `GPI_PIN: rd_mux[NPIN-1:0] = s2_ff;
            `GPI_STS: rd_mux[NCH-1:0] = sts_ff;
            `GPI_STS_MSK: rd_mux[NCH-1:0] = smsk_ff;
            default: rd_mux = '0;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= `GPI_RST;
      end else begin
         rdata_o <= rd_i ? rd_mux : `GPI_RST;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_dir_oe;
      w_dir_s && wdata_i[0] |=> dir_ff[0] ##1 !gpio_oe_n_o[0];
   endproperty
   a_dir_oe: assert property (p_dir_oe) else $error("dir set not driven");

   property p_keep;
      w_dat_s && !wdata_i[1] |=> out_ff[1] == $past(out_ff[1]);
   endproperty
   a_keep: assert property (p_keep) else $error("unwritten bit moved");

   // A channel with every pin masked must stay quiet whatever its latches hold
   property p_mask;
      msk_ff[0] == 32'h0000_0000 |=> !ch_irq_o[0];
   endproperty
   a_mask: assert property (p_mask) else $error("masked channel fired");

   property p_out_trig;
      dir_ff[0] && !edge_ff[0] && (out_ff[0] ^ pol_ff[0]) |=> lat_ff[0];
   endproperty
   a_out_trig: assert property (p_out_trig) else $error("output trigger lost");

   property p_fall_only_both;
      edge_ff[0] && !both_ff[0] && fall[0] && !lat_ff[0] |=> !lat_ff[0];
   endproperty
   a_fall_only_both: assert property (p_fall_only_both) else $error("falling edge latched");

   property p_sticky;
      edge_ff[0] && lat_ff[0] && !clr[0] |=> lat_ff[0];
   endproperty
   a_sticky: assert property (p_sticky) else $error("latch dropped");

   property p_set_wins;
      hit[0] && clr[0] |=> lat_ff[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

   property p_sync;
      ##2 s2_ff == $past(gpio_in_i, 2);
   endproperty
   a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

   property p_pin_read;
      rd_i && addr_i == `GPI_PIN |=> rdata_o[NPIN-1:0] == $past(s2_ff);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin read wrong");

   property p_irq;
      req[1] && smsk_ff[1] |=> irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("summary irq missing");

   c_edge: cover property (edge_ff[0] && rise[0] ##1 lat_ff[0]);
   c_chirq: cover property (ch_irq_o[0] ##[1:20] !ch_irq_o[0]);
   c_irq: cover property (irq_o ##1 sts_rd);
endmodule : gpi_pint

// ---- tb/gpi_pin_model.sv ----
`timescale 1ns/1ps
// Pad level seen from outside: the port drives while its enable is low,
// otherwise the external source sets the level
module gpi_pin_model (
   input wire logic [31:0] ext_i,
   input wire logic [31:0] drv_i,
   input wire logic [31:0] oe_n_i,
   output logic [31:0] pin_o
);
   // Resolve each pad from both parties; no pin is ever left floating
   assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & drv_i);
endmodule : gpi_pin_model

// ---- tb/tb_gpio_port_with_pin_interrupts.sv ----
`timescale 1ns/1ps
`include "gpi_cfg.svh"
module tb_gpio_port_with_pin_interrupts
   import gpi_pkg::*;
;
   logic core_clk_i = 1'b0, arst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_seen = 1'b0;
   gpi_addr_t addr_i = 9'h000;
   gpi_word_t wdata_i = 32'h0000_0000, rdata_o;
   logic [31:0] ext = 32'h0000_0000, pins, gpio_out_o, gpio_oe_n_o, r1, r2, r3;
   logic [5:0] ch_irq_o;
   logic irq_o;
   int fails = 0, n_compared = 0, cyc = 0;
   gpi_word_t exp_q[$];

   gpi_pint u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .gpio_in_i(pins), .rdata_o(rdata_o),
      .gpio_out_o(gpio_out_o), .gpio_oe_n_o(gpio_oe_n_o), .ch_irq_o(ch_irq_o),
      .irq_o(irq_o));
   gpi_pin_model u_pins (.ext_i(ext), .drv_i(gpio_out_o), .oe_n_i(gpio_oe_n_o), .pin_o(pins));

   // 20 MHz system clock
   initial begin
      forever #25 core_clk_i = ~core_clk_i;
   end

   task automatic test_done();
      // A read whose data never showed up counts as a mismatch
      if (exp_q.size() != 0) fails++;
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   task automatic cmp_rd(input gpi_word_t got, input gpi_word_t exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t read got %h exp %h", $time, got, exp);
      end
   endtask : cmp_rd

   task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp_port

   // One bus cycle; a read leaves its expected word for the monitor
   task automatic bus(input logic w, input gpi_addr_t a, input gpi_word_t d);
      @(posedge core_clk_i);
      wr_i <= w;
      rd_i <= !w;
      addr_i <= a;
      wdata_i <= d;
      if (!w) exp_q.push_back(d);
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
   endtask : bus

   function automatic gpi_addr_t ca(input int c, input logic [4:0] o);
      return `GPI_CH_BASE + gpi_addr_t'(c << `GPI_CH_SHIFT) + gpi_addr_t'(o);
   endfunction : ca

   task automatic pin0(input logic v);
      @(posedge core_clk_i);
      ext[0] <= v;
   endtask : pin0

   // Bounded wait, since request latency is a few cycles after the cause
   task automatic wait_irq(input logic [5:0] e);
      for (int i = 0; i < 12 && ch_irq_o !== e; i++) @(negedge core_clk_i);
      cmp_port(32'(ch_irq_o), 32'(e), "channel requests");
   endtask : wait_irq

   task automatic clr(input logic [5:0] e);
      bus(1'b1, ca(0, `GPI_C_LATCH), 32'h0000_0001);
      wait_irq(e);
   endtask : clr

   // Read data stands only in the cycle after the strobe; look mid-cycle
   always @(posedge core_clk_i) rd_seen <= rd_i;
   always @(negedge core_clk_i) begin
      if (rd_seen) cmp_rd(rdata_o, exp_q.pop_front());
   end

   // Hang guard, well above the expected run length
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         test_done();
      end
   end

   initial begin
      r1 = $urandom(32'h0000_00b7);
      r1 = $urandom;
      r2 = $urandom;
      r3 = $urandom;
      repeat (4) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      ext <= r3;
      // Direction and data through set and clear addresses
      bus(1'b0, `GPI_DIR, 32'h0000_0000);
      @(negedge core_clk_i);
      cmp_port(gpio_oe_n_o, 32'hFFFF_FFFF, "enable after reset");
      bus(1'b1, `GPI_DIR_SET, r1);
      bus(1'b1, `GPI_DIR_CLR, r2);
      bus(1'b0, `GPI_DIR, r1 & ~r2);
      bus(1'b1, `GPI_DATA_SET, r2);
      bus(1'b1, `GPI_DATA_CLR, r1);
      bus(1'b0, `GPI_DATA, r2 & ~r1);
      @(negedge core_clk_i);
      cmp_port(gpio_oe_n_o, ~(r1 & ~r2), "direction");
      cmp_port(gpio_out_o, r2 & ~r1, "output data");
      bus(1'b0, `GPI_PIN, ~(r1 & ~r2) & r3);
      // Plain writes replace the whole word; aliases read the same register
      bus(1'b1, `GPI_DIR, r2);
      bus(1'b1, `GPI_DATA, r3);
      bus(1'b0, `GPI_DIR_CLR, r2);
      bus(1'b0, `GPI_DATA_SET, r3);
      bus(1'b1, `GPI_DIR_CLR, 32'hFFFF_FFFF);
      bus(1'b1, `GPI_DATA_CLR, 32'hFFFF_FFFF);
      ext <= 32'h0000_0000;
      // Half-port 0 to every channel, pin 0 rising edge only
      bus(1'b1, `GPI_EDGE, 32'h0000_0001);
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, ca(c, `GPI_C_ASSIGN), 32'h0000_0080);
         bus(1'b1, ca(c, `GPI_C_LATCH), 32'hFFFF_FFFF);
         bus(1'b1, ca(c, `GPI_C_MSK_S), 32'h0000_0001);
      end
      bus(1'b1, `GPI_STS_MSK, 32'h0000_003F);
      // Configuration reads back as written
      bus(1'b0, ca(2, `GPI_C_ASSIGN), 32'h0000_0080);
      bus(1'b0, ca(2, `GPI_C_MSK_C), 32'h0000_0001);
      bus(1'b0, `GPI_STS_MSK, 32'h0000_003F);
      bus(1'b0, `GPI_EDGE, 32'h0000_0001);
      pin0(1'b1);
      wait_irq(6'h3F);
      cmp_port(32'(irq_o), 32'h0000_0001, "summary request");
      pin0(1'b0);
      bus(1'b0, ca(3, `GPI_C_LATCH), 32'h0000_0001);
      bus(1'b0, `GPI_STS, 32'h0000_003F);
      clr(6'h00);
      // Status stays sticky after the cause is gone; the read drops it
      bus(1'b0, `GPI_STS, 32'h0000_003F);
      @(negedge core_clk_i);
      cmp_port(32'(irq_o), 32'h0000_0000, "summary after read");
      pin0(1'b1);
      wait_irq(6'h3F);
      clr(6'h00);
      pin0(1'b0);
      repeat (8) @(negedge core_clk_i);
      cmp_port(32'(ch_irq_o), 32'h0000_0000, "falling in rising mode");
      // Both edges
      bus(1'b1, `GPI_BOTH, 32'h0000_0001);
      pin0(1'b1);
      wait_irq(6'h3F);
      clr(6'h00);
      pin0(1'b0);
      wait_irq(6'h3F);
      clr(6'h00);
      bus(1'b1, `GPI_BOTH, 32'h0000_0000);
      // Masked channel still latches and shows its pin
      bus(1'b1, ca(0, `GPI_C_MSK_C), 32'h0000_0001);
      pin0(1'b1);
      wait_irq(6'h3E);
      bus(1'b0, ca(0, `GPI_C_LATCH), 32'h0000_0001);
      bus(1'b0, ca(0, `GPI_C_REQ), 32'h0000_0000);
      bus(1'b0, ca(0, `GPI_C_PINST), 32'h0000_0001);
      pin0(1'b0);
      clr(6'h00);
      // Output pin interrupts from written data
      bus(1'b1, `GPI_DIR_SET, 32'h0000_0001);
      bus(1'b1, `GPI_DATA_SET, 32'h0000_0001);
      wait_irq(6'h3E);
      bus(1'b1, `GPI_DATA_CLR, 32'h0000_0001);
      clr(6'h00);
      // Level mode, active low
      bus(1'b1, `GPI_EDGE, 32'h0000_0000);
      bus(1'b1, `GPI_POL, 32'h0000_0001);
      wait_irq(6'h3E);
      bus(1'b1, `GPI_DATA_SET, 32'h0000_0001);
      clr(6'h00);
      // Half-port 1 on lane 2 of channel 5, pin 9 held high in level mode
      bus(1'b1, ca(5, `GPI_C_ASSIGN), 32'h0081_0000);
      ext[9] <= 1'b1;
      bus(1'b1, ca(5, `GPI_C_LATCH), 32'h00FF_0000);
      bus(1'b0, ca(5, `GPI_C_PINST), 32'h0002_0000);
      bus(1'b0, ca(5, `GPI_C_LATCH), 32'h0002_0000);
      bus(1'b0, 9'h1FC, 32'h0000_0000);
      repeat (2) @(posedge core_clk_i);
      test_done();
   end
endmodule : tb_gpio_port_with_pin_interrupts
